// >>> sebsl_pkg.sv
// Constants and types for the serial EEPROM board setup loader.
package sebsl_pkg;

  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 6;

  // Register indices of the CPU access port.
  localparam logic [2:0] IDX_CONTROL = 3'h0;
  localparam logic [2:0] IDX_CONFIG  = 3'h1;
  localparam logic [2:0] IDX_BASE    = 3'h2;
  localparam logic [2:0] IDX_IA0     = 3'h3;
  localparam logic [2:0] IDX_IA1     = 3'h4;
  localparam logic [2:0] IDX_IA2     = 3'h5;
  localparam logic [2:0] IDX_POINTER = 3'h6;
  localparam logic [2:0] IDX_GENERAL = 3'h7;

  // Control register bit positions.
  localparam int unsigned CTL_SELECT_BIT = 0;
  localparam int unsigned CTL_LOAD_BIT   = 1;
  localparam int unsigned CTL_SAVE_BIT   = 2;

  // EEPROM word map.
  localparam logic [5:0] EE_STRAP_STRIDE = 6'h04;
  localparam logic [5:0] EE_BASE_OFFSET  = 6'h01;
  localparam logic [5:0] EE_IA_FIRST     = 6'h20;
  localparam logic [2:0] STRAP_DEFAULT   = 3'h7;

  // Reset values; arbitrary neutral defaults.
  localparam logic [15:0] CONFIG_DEFAULT = 16'h0000;
  localparam logic [15:0] BASE_DEFAULT   = 16'h0000;
  localparam logic [15:0] IA_DEFAULT     = 16'h0000;

  // Serial frame layout.
  localparam logic [1:0] OP_READ    = 2'h2;
  localparam logic [1:0] OP_WRITE   = 2'h1;
  localparam logic [1:0] OP_ENABLE  = 2'h0;
  localparam logic [5:0] ENABLE_ADR = 6'h30;
  localparam logic [4:0] HDR_BITS   = 5'h09;
  localparam logic [4:0] FRAME_BITS = 5'h19;

  // Core cycles between reset release and the boot load.
  localparam logic [3:0] BOOT_SETTLE = 4'h8;

  typedef enum logic [1:0] {
    JOB_LOAD_NORM = 2'b00,
    JOB_SAVE_NORM = 2'b01,
    JOB_LOAD_GP   = 2'b10,
    JOB_SAVE_GP   = 2'b11
  } sebsl_job_t;

  typedef struct packed {
    logic        wr;
    logic [5:0]  addr;
    logic [15:0] data;
  } sebsl_req_t;

  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
  } sebsl_pins_t;

endpackage

// >>> sebsl_wire.sv
// Serial EEPROM word engine running in the link clock domain.
`timescale 1ns/10ps
module sebsl_wire
  import sebsl_pkg::*;
(
  input  wire logic        link_clk,
  input  wire logic        core_rst,
  input  wire logic        req_tgl,
  input  wire sebsl_req_t  req_word,
  output logic             done_tgl,
  output logic [15:0]      rdata,
  output sebsl_pins_t      pins,
  input  wire logic        ee_do
);

  typedef enum logic [2:0] {
    W_IDLE  = 3'b000,
    W_SHIFT = 3'b001,
    W_GAP   = 3'b010,
    W_READY = 3'b011,
    W_DONE  = 3'b100
  } sebsl_wstate_t;

  logic          rst_s1;
  logic          rst;
  logic          req_s1;
  logic          req_s2;
  logic          req_s3;
  logic          do_s1;
  logic          do_s;
  sebsl_wstate_t wstate;
  logic [24:0]   sh;
  logic [4:0]    cnt;
  logic [4:0]    nbits;
  logic          phase;
  logic          enable_first;
  sebsl_req_t    job;

  wire req_evt = req_s2 ^ req_s3;
  wire last_bit = (cnt == 5'(nbits - 5'h01));

  // Reset and pin inputs are all brought in through two flip-flops.
  always_ff @(posedge link_clk)
  begin
    rst_s1 <= core_rst;
    rst    <= rst_s1;
    do_s1  <= ee_do;
    do_s   <= do_s1;
  end

  always_ff @(posedge link_clk)
  begin
    if (rst)
    begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end
    else
    begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  // A write is preceded by an erase/write enable frame, then the ready wait.
  always_ff @(posedge link_clk)
  begin
    if (rst)
    begin
      wstate       <= W_IDLE;
      sh           <= 25'h0000000;
      cnt          <= 5'h00;
      nbits        <= 5'h00;
      phase        <= 1'b0;
      enable_first <= 1'b0;
      job          <= '0;
      pins         <= '0;
      done_tgl     <= 1'b0;
      rdata        <= 16'h0000;
    end
    else
    begin
      case (wstate)
        W_IDLE:
        begin
          pins <= '0;
          if (req_evt)
          begin
            job    <= req_word;
            cnt    <= 5'h00;
            phase  <= 1'b0;
            pins.cs <= 1'b1;
            wstate <= W_SHIFT;
            if (req_word.wr)
            begin
              sh           <= {1'b1, OP_ENABLE, ENABLE_ADR, 16'h0000};
              nbits        <= HDR_BITS;
              enable_first <= 1'b1;
            end
            else
            begin
              sh           <= {1'b1, OP_READ, req_word.addr, 16'h0000};
              // One extra clock lets the last data bit get through the input synchroniser.
              nbits        <= 5'(FRAME_BITS + 5'h01);
              enable_first <= 1'b0;
            end
          end
        end
        W_SHIFT:
        begin
          pins.cs <= 1'b1;
          phase <= ~phase;
          if (!phase)
          begin
            pins.sk <= 1'b0;
            pins.di <= sh[24];
          end
          else
          begin
            pins.sk <= 1'b1;
            sh      <= {sh[23:0], do_s};
            cnt     <= 5'(cnt + 5'h01);
            if (last_bit)
            begin
              wstate <= W_GAP;
            end
          end
        end
        W_GAP:
        begin
          pins <= '0;
          cnt  <= 5'h00;
          // Chip select drops for one cycle so the part takes each instruction afresh.
          if (enable_first)
          begin
            enable_first <= 1'b0;
            sh           <= {1'b1, OP_WRITE, job.addr, job.data};
            nbits        <= FRAME_BITS;
            wstate       <= W_SHIFT;
          end
          else if (job.wr)
          begin
            wstate <= W_READY;
          end
          else
          begin
            wstate <= W_DONE;
          end
        end
        W_READY:
        begin
          // The part signals the end of its internal write by raising its output.
          // The first samples still carry the deselected line, so they are skipped.
          pins.cs <= 1'b1;
          if (cnt != 5'h03)
          begin
            cnt <= 5'(cnt + 5'h01);
          end
          else if (do_s)
          begin
            pins.cs <= 1'b0;
            wstate  <= W_DONE;
          end
        end
        W_DONE:
        begin
          rdata    <= sh[15:0];
          done_tgl <= ~done_tgl;
          wstate   <= W_IDLE;
        end
        default:
        begin
          wstate <= W_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> sebsl_loader.sv
// Board setup loader: EEPROM load of the setup registers and store of configuration and base; configuration and base words are strap-indexed.
`timescale 1ns/10ps
module sebsl_loader
  import sebsl_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        SRST,
  input  wire logic        LINK_CLK,
  input  wire logic [2:0]  BOARD_SELECT_STRAPS,
  input  wire logic        EEPROM_PRESENT_STRAP,
  input  wire logic        CPU_WR,
  input  wire logic        CPU_RD,
  input  wire logic [2:0]  CPU_IDX,
  input  wire logic [15:0] CPU_WDATA,
  output logic [15:0]      CPU_RDATA,
  output logic             CPU_ACK,
  output logic [15:0]      CONFIG_REG,
  output logic [15:0]      BASE_REG,
  output logic [15:0]      IA0,
  output logic [15:0]      IA1,
  output logic [15:0]      IA2,
  output logic             EE_CS,
  output logic             EE_SK,
  output logic             EE_DI,
  input  wire logic        EE_DO
);

  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_IDLE = 3'b001,
    ST_PLAN = 3'b010,
    ST_SEND = 3'b011,
    ST_WAIT = 3'b100,
    ST_NEXT = 3'b101
  } sebsl_state_t;

  logic [2:0]   strap_s1;
  logic [2:0]   strap_s2;
  logic         present_s1;
  logic         present_s2;
  logic [3:0]   boot_cnt;
  sebsl_state_t state;
  sebsl_state_t next_state;
  sebsl_job_t   job;
  logic [2:0]   step;
  logic [2:0]   strap_job;
  logic         ctl_select;
  logic [15:0]  ia_reg [0:2];
  logic [15:0]  pointer_reg;
  logic [15:0]  general_reg;
  logic         req_tgl;
  sebsl_req_t   req_word;
  logic         done_tgl;
  logic [15:0]  link_rdata;
  logic         done_s1;
  logic         done_s2;
  logic         done_s3;
  sebsl_pins_t  pins;

  // Number of the last step of a job.
  function automatic logic [2:0] job_last(input sebsl_job_t j);
    case (j)
      JOB_LOAD_NORM: job_last = 3'h4;
      JOB_SAVE_NORM: job_last = 3'h1;
      default:       job_last = 3'h0;
    endcase
  endfunction

  // Default straps keep the built-in configuration and base during a load.
  function automatic logic step_used(input sebsl_job_t j, input logic [2:0] s,
                                     input logic [2:0] strap);
    step_used = !(j == JOB_LOAD_NORM && strap == STRAP_DEFAULT && s < 3'h2);
  endfunction

  // EEPROM word address of a step.
  function automatic logic [5:0] step_addr(input sebsl_job_t j, input logic [2:0] s,
                                           input logic [2:0] strap, input logic [15:0] ptr);
    logic [5:0] cfg_addr;
    cfg_addr = 6'({3'h0, strap} * EE_STRAP_STRIDE);
    if (j == JOB_LOAD_GP || j == JOB_SAVE_GP)
    begin
      step_addr = ptr[5:0];
    end
    else if (s == 3'h0)
    begin
      step_addr = cfg_addr;
    end
    else if (s == 3'h1)
    begin
      step_addr = cfg_addr + EE_BASE_OFFSET;
    end
    else
    begin
      step_addr = 6'(EE_IA_FIRST + {3'h0, s} - 6'h02);
    end
  endfunction

  wire busy        = (state != ST_IDLE);
  wire done_evt    = done_s2 ^ done_s3;
  wire is_load     = (job == JOB_LOAD_NORM) || (job == JOB_LOAD_GP);
  wire is_gp       = (job == JOB_LOAD_GP) || (job == JOB_SAVE_GP);
  wire cpu_wr_ok   = CPU_WR && !busy;
  wire ctl_write   = cpu_wr_ok && (CPU_IDX == IDX_CONTROL);
  wire trig_load   = ctl_write && CPU_WDATA[CTL_LOAD_BIT];
  wire trig_save   = ctl_write && CPU_WDATA[CTL_SAVE_BIT] && !CPU_WDATA[CTL_LOAD_BIT];
  wire trig_any    = trig_load || trig_save;
  wire new_select  = CPU_WDATA[CTL_SELECT_BIT];
  wire boot_over   = (boot_cnt == 4'(BOOT_SETTLE - 4'h1));
  wire last_step   = (step == job_last(job));
  wire cur_used    = step_used(job, step, strap_job);
  wire [5:0] cur_addr = step_addr(job, step, strap_job, pointer_reg);
  wire load_done   = (state == ST_WAIT) && done_evt && is_load;
  wire ld_config   = load_done && !is_gp && (step == 3'h0);
  wire ld_base     = load_done && !is_gp && (step == 3'h1);
  wire ld_general  = load_done && is_gp;
  wire [1:0] ia_idx = 2'(step - 3'h2);

  wire sebsl_job_t next_job = trig_load ? (new_select ? JOB_LOAD_GP : JOB_LOAD_NORM)
                                        : (new_select ? JOB_SAVE_GP : JOB_SAVE_NORM);

  wire [15:0] save_data = is_gp ? general_reg :
                          (step == 3'h0) ? CONFIG_REG : BASE_REG;

  // Both triggers read high for the whole access, boot load included.
  wire [15:0] control_view = {13'h0000, busy, busy, ctl_select};

  wire [15:0] reg_view = (CPU_IDX == IDX_CONFIG)  ? CONFIG_REG  :
                         (CPU_IDX == IDX_BASE)    ? BASE_REG    :
                         (CPU_IDX == IDX_IA0)     ? ia_reg[0]   :
                         (CPU_IDX == IDX_IA1)     ? ia_reg[1]   :
                         (CPU_IDX == IDX_IA2)     ? ia_reg[2]   :
                         (CPU_IDX == IDX_POINTER) ? pointer_reg :
                         (CPU_IDX == IDX_GENERAL) ? general_reg : 16'h0000;

  wire [15:0] read_view = (CPU_IDX == IDX_CONTROL) ? control_view :
                          busy ? 16'h0000 : reg_view;

  // Straps are pins and pass two flip-flops before use.
  always_ff @(posedge CORE_CLK)
  begin
    strap_s1   <= BOARD_SELECT_STRAPS;
    strap_s2   <= strap_s1;
    present_s1 <= EEPROM_PRESENT_STRAP;
    present_s2 <= present_s1;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
    end
    else
    begin
      done_s1 <= done_tgl;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
    end
  end

  always_comb
  begin
    next_state = state;
    case (state)
      ST_BOOT:
      begin
        if (boot_over)
        begin
          next_state = present_s2 ? ST_PLAN : ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        if (trig_any && present_s2)
        begin
          next_state = ST_PLAN;
        end
      end
      ST_PLAN:
      begin
        next_state = cur_used ? ST_SEND : ST_NEXT;
      end
      ST_SEND:
      begin
        next_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (done_evt)
        begin
          next_state = ST_NEXT;
        end
      end
      ST_NEXT:
      begin
        next_state = last_step ? ST_IDLE : ST_PLAN;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      state    <= ST_BOOT;
      boot_cnt <= 4'h0;
    end
    else
    begin
      state    <= next_state;
      boot_cnt <= boot_over ? boot_cnt : 4'(boot_cnt + 4'h1);
    end
  end

  // The strap value is frozen per job so all words of one job use one slot.
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      job       <= JOB_LOAD_NORM;
      step      <= 3'h0;
      strap_job <= 3'h0;
    end
    else if ((state == ST_BOOT) && boot_over)
    begin
      job       <= JOB_LOAD_NORM;
      step      <= 3'h0;
      strap_job <= strap_s2;
    end
    else if ((state == ST_IDLE) && trig_any)
    begin
      job       <= next_job;
      step      <= 3'h0;
      strap_job <= strap_s2;
    end
    else if ((state == ST_NEXT) && !last_step)
    begin
      step <= 3'(step + 3'h1);
    end
  end

  // Request word is held stable until the link side answers.
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      req_tgl  <= 1'b0;
      req_word <= '0;
    end
    else if (state == ST_SEND)
    begin
      req_tgl       <= ~req_tgl;
      req_word.wr   <= !is_load;
      req_word.addr <= cur_addr;
      req_word.data <= save_data;
    end
  end

  // Only the select bit is stored; the triggers are the busy state itself.
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      ctl_select <= 1'b0;
    end
    else if (ctl_write)
    begin
      ctl_select <= new_select;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      CONFIG_REG <= CONFIG_DEFAULT;
      BASE_REG   <= BASE_DEFAULT;
    end
    else
    begin
      if (ld_config)
      begin
        CONFIG_REG <= link_rdata;
      end
      else if (cpu_wr_ok && CPU_IDX == IDX_CONFIG)
      begin
        CONFIG_REG <= CPU_WDATA;
      end
      if (ld_base)
      begin
        BASE_REG <= link_rdata;
      end
      else if (cpu_wr_ok && CPU_IDX == IDX_BASE)
      begin
        BASE_REG <= CPU_WDATA;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_ia
      wire ld_ia  = load_done && !is_gp && (step >= 3'h2) && (ia_idx == 2'(gi));
      wire cpu_ia = cpu_wr_ok && (CPU_IDX == 3'(IDX_IA0 + 3'(gi)));
      always_ff @(posedge CORE_CLK)
      begin
        if (SRST)
        begin
          ia_reg[gi] <= IA_DEFAULT;
        end
        else if (ld_ia)
        begin
          ia_reg[gi] <= link_rdata;
        end
        else if (cpu_ia)
        begin
          ia_reg[gi] <= CPU_WDATA;
        end
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      pointer_reg <= 16'h0000;
      general_reg <= 16'h0000;
    end
    else
    begin
      if (cpu_wr_ok && CPU_IDX == IDX_POINTER)
      begin
        pointer_reg <= CPU_WDATA;
      end
      if (ld_general)
      begin
        general_reg <= link_rdata;
      end
      else if (cpu_wr_ok && CPU_IDX == IDX_GENERAL)
      begin
        general_reg <= CPU_WDATA;
      end
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      CPU_RDATA <= 16'h0000;
      CPU_ACK   <= 1'b0;
    end
    else
    begin
      CPU_ACK <= CPU_WR || CPU_RD;
      if (CPU_RD)
      begin
        CPU_RDATA <= read_view;
      end
    end
  end

  assign IA0   = ia_reg[0];
  assign IA1   = ia_reg[1];
  assign IA2   = ia_reg[2];
  assign EE_CS = pins.cs;
  assign EE_SK = pins.sk;
  assign EE_DI = pins.di;

  sebsl_wire u_wire (
    .link_clk (LINK_CLK),
    .core_rst (SRST),
    .req_tgl  (req_tgl),
    .req_word (req_word),
    .done_tgl (done_tgl),
    .rdata    (link_rdata),
    .pins     (pins),
    .ee_do    (EE_DO)
  );

endmodule

// >>> sebsl_loader_assertions.sv
// Concurrent checks on the ports of the board setup loader.
`timescale 1ns/10ps
module sebsl_loader_assertions
  import sebsl_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        SRST,
  input wire logic        LINK_CLK,
  input wire logic        EEPROM_PRESENT_STRAP,
  input wire logic        CPU_WR,
  input wire logic        CPU_RD,
  input wire logic [2:0]  CPU_IDX,
  input wire logic [15:0] CPU_RDATA,
  input wire logic        CPU_ACK,
  input wire logic [15:0] CONFIG_REG,
  input wire logic [15:0] BASE_REG,
  input wire logic [15:0] IA0,
  input wire logic        EE_CS,
  input wire logic        EE_SK
);
  sequence s_strobe;
    CPU_WR || CPU_RD;
  endsequence
  sequence s_boot_gap;
    !EE_CS [*6];
  endsequence
  sequence s_busy_read;
    EE_CS && CPU_RD;
  endsequence

  a_ack_pulse: assert property (@(posedge CORE_CLK) disable iff (SRST)
    s_strobe |=> CPU_ACK) else $error("ack missing");
  a_ack_quiet: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !(CPU_WR || CPU_RD) |=> !CPU_ACK) else $error("ack without strobe");
  a_reset_defaults: assert property (@(posedge CORE_CLK) SRST |=>
    CONFIG_REG == CONFIG_DEFAULT && BASE_REG == BASE_DEFAULT && IA0 == IA_DEFAULT && !CPU_ACK)
    else $error("reset values wrong");
  a_boot_start: assert property (@(posedge CORE_CLK) disable iff (SRST)
    $fell(SRST) && EEPROM_PRESENT_STRAP |-> s_boot_gap ##[1:40] EE_CS)
    else $error("boot load missing");
  a_no_ee_quiet: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !EEPROM_PRESENT_STRAP [*8] |-> !EE_CS) else $error("access without eeprom");
  a_busy_ctl: assert property (@(posedge CORE_CLK) disable iff (SRST)
    s_busy_read ##0 CPU_IDX == IDX_CONTROL |=> CPU_RDATA[2:1] == 2'b11)
    else $error("triggers not high while busy");
  a_blocked_zero: assert property (@(posedge CORE_CLK) disable iff (SRST)
    s_busy_read ##0 CPU_IDX != IDX_CONTROL |=> CPU_RDATA == 16'h0000)
    else $error("read not blocked");
  a_rdata_hold: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !CPU_RD |=> $stable(CPU_RDATA)) else $error("read data moved");
  a_sk_frame: assert property (@(posedge LINK_CLK) disable iff (SRST)
    EE_SK |-> EE_CS) else $error("clock outside frame");
endmodule

bind sebsl_loader sebsl_loader_assertions sebsl_loader_assertions_i (
  .CORE_CLK(CORE_CLK), .SRST(SRST), .LINK_CLK(LINK_CLK),
  .EEPROM_PRESENT_STRAP(EEPROM_PRESENT_STRAP), .CPU_WR(CPU_WR), .CPU_RD(CPU_RD),
  .CPU_IDX(CPU_IDX), .CPU_RDATA(CPU_RDATA), .CPU_ACK(CPU_ACK), .CONFIG_REG(CONFIG_REG),
  .BASE_REG(BASE_REG), .IA0(IA0), .EE_CS(EE_CS), .EE_SK(EE_SK));

// >>> sebsl_ee.sv
// Behavioural model of the 64 x 16 three-wire serial EEPROM.
`timescale 1ns/10ps
module sebsl_ee
  import sebsl_pkg::*;
#(
  parameter int BUSY_NS = 200
)
(
  input  wire logic cs,
  input  wire logic sk,
  input  wire logic di,
  output logic      do_o
);
  logic [15:0] mem [64];
  logic [4:0]  cnt = 5'h00;
  logic [1:0]  op = 2'h0;
  logic [5:0]  adr = 6'h00;
  logic [15:0] shift = 16'h0000;
  logic        ready = 1'b0;
  logic        dreg = 1'b0;

  // Deselect aborts a frame, so a reset in mid-word leaves the array untouched.
  always @(posedge sk or negedge cs)
  begin
    if (!cs)
      cnt <= 5'h00;
    else
    begin
      shift <= {shift[14:0], di};
      cnt <= cnt + 5'h01;
      if (cnt == 5'h00 && di)
        ready <= 1'b0;
      if (cnt == 5'h02)
        op <= {shift[0], di};
      if (cnt == 5'h08)
        adr <= {shift[4:0], di};
      if (cnt == 5'h18 && op == OP_WRITE)
        mem[adr] <= {shift[14:0], di};
      if (cnt == 5'h18 && op == OP_WRITE)
        ready <= #(BUSY_NS) 1'b1;
    end
  end

  // A released line shows the inverse of its last level, never a held copy.
  always @(negedge sk or negedge cs)
  begin
    if (!cs)
      dreg <= ~dreg;
    else if (op == OP_READ && cnt >= 5'h09 && cnt <= 5'h18)
      dreg <= mem[adr][5'h18 - cnt];
  end
  assign do_o = (cs && cnt == 5'h00) ? ready : dreg;
endmodule

// >>> tb.sv
// Self-checking bench of the board setup loader.
`timescale 1ns/10ps
module tb;
  import sebsl_pkg::*;
  logic        core_clk, link_clk, srst, cpu_wr, cpu_rd, present, polling;
  logic        ee_cs, ee_sk, ee_di, ee_do, cpu_ack;
  logic        rd_last = 1'b0;
  logic [2:0]  straps, cpu_idx;
  logic [15:0] cpu_wdata, cpu_rdata, cfg, base, ia0, ia1, ia2, v, w, c0;
  logic [31:0] nt;
  logic [31:0] notes[$];
  int          n_mismatch = 0;
  int          cmp_count = 0;

  sebsl_loader sebsl_loader_i (.CORE_CLK(core_clk), .SRST(srst), .LINK_CLK(link_clk),
    .BOARD_SELECT_STRAPS(straps), .EEPROM_PRESENT_STRAP(present), .CPU_WR(cpu_wr),
    .CPU_RD(cpu_rd), .CPU_IDX(cpu_idx), .CPU_WDATA(cpu_wdata), .CPU_RDATA(cpu_rdata),
    .CPU_ACK(cpu_ack), .CONFIG_REG(cfg), .BASE_REG(base), .IA0(ia0), .IA1(ia1),
    .IA2(ia2), .EE_CS(ee_cs), .EE_SK(ee_sk), .EE_DI(ee_di), .EE_DO(ee_do));
  sebsl_ee sebsl_ee_i (.cs(ee_cs), .sk(ee_sk), .di(ee_di), .do_o(ee_do));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #3;
    forever #6 link_clk = ~link_clk;
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Read results are matched in order against the notes left by the driver.
  always @(posedge core_clk) rd_last <= cpu_rd;
  always @(negedge core_clk)
  begin
    if (rd_last && !polling)
    begin
      check("read ack", 16'h0001, {15'h0000, cpu_ack});
      nt = notes.pop_front();
      check("read data", nt[15:0], cpu_rdata & nt[31:16]);
    end
  end

  task automatic wr(input logic [2:0] idx, input logic [15:0] d);
    cpu_idx = idx;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge core_clk);
    cpu_wr = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic rd(input logic [2:0] idx, input logic [15:0] exp, input logic [15:0] m = 16'hffff);
    notes.push_back({m, exp & m});
    cpu_idx = idx;
    cpu_rd = 1'b1;
    @(negedge core_clk);
    cpu_rd = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic poll();
    int i;
    polling = 1'b1;
    for (i = 0; i < 3000; i++)
    begin
      cpu_idx = IDX_CONTROL;
      cpu_rd = 1'b1;
      @(negedge core_clk);
      cpu_rd = 1'b0;
      @(negedge core_clk);
      if (cpu_rdata[2:1] === 2'b00)
        break;
    end
    polling = 1'b0;
    if (i == 3000)
    begin
      check("poll done", 16'h0000, 16'h0006);
      stop_test();
    end
  endtask

  task automatic do_reset(input logic [2:0] s, input logic p);
    srst = 1'b1;
    straps = s;
    present = p;
    repeat (16) @(negedge core_clk);
    srst = 1'b0;
    poll();
  endtask

  task automatic check_setup(input logic [2:0] s);
    logic [15:0] c, b;
    c = (s == STRAP_DEFAULT) ? CONFIG_DEFAULT : sebsl_ee_i.mem[{1'b0, s, 2'b00}];
    b = (s == STRAP_DEFAULT) ? BASE_DEFAULT : sebsl_ee_i.mem[{1'b0, s, 2'b01}];
    rd(IDX_CONFIG, c);
    rd(IDX_BASE, b);
    rd(IDX_IA0, sebsl_ee_i.mem[6'h20]);
    rd(IDX_IA1, sebsl_ee_i.mem[6'h21]);
    rd(IDX_IA2, sebsl_ee_i.mem[6'h22]);
    check("config port", c, cfg);
    check("base port", b, base);
    check("ia0 port", sebsl_ee_i.mem[6'h20], ia0);
    check("ia1 port", sebsl_ee_i.mem[6'h21], ia1);
    check("ia2 port", sebsl_ee_i.mem[6'h22], ia2);
  endtask

  initial
  begin
    srst = 1'b1;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_idx = 3'h0;
    cpu_wdata = 16'h0000;
    straps = 3'h0;
    present = 1'b1;
    polling = 1'b0;
    void'($urandom(7));
    for (int i = 0; i < 64; i++)
      sebsl_ee_i.mem[i] = 16'($urandom);
    do_reset(3'h0, 1'b1);
    check_setup(3'h0);
    c0 = cfg;
    rd(IDX_CONTROL, 16'h0000, 16'h0007);
    w = 16'($urandom);
    wr(IDX_POINTER, w);
    wr(IDX_CONTROL, 16'h0003);
    poll();
    rd(IDX_GENERAL, sebsl_ee_i.mem[w[5:0]]);
    v = 16'($urandom);
    w = 16'($urandom);
    wr(IDX_GENERAL, v);
    wr(IDX_POINTER, w);
    wr(IDX_CONTROL, 16'h0005);
    rd(IDX_CONTROL, 16'h0007, 16'h0007);
    rd(IDX_CONFIG, 16'h0000);
    wr(IDX_CONFIG, ~c0);
    poll();
    check("saved word", v, sebsl_ee_i.mem[w[5:0]]);
    rd(IDX_CONFIG, c0);
    v = 16'($urandom);
    w = 16'($urandom);
    wr(IDX_CONFIG, v);
    wr(IDX_BASE, w);
    wr(IDX_CONTROL, 16'h0004);
    poll();
    check("saved config", v, sebsl_ee_i.mem[6'h00]);
    check("saved base", w, sebsl_ee_i.mem[6'h01]);
    sebsl_ee_i.mem[0] = 16'($urandom);
    sebsl_ee_i.mem[32] = 16'($urandom);
    wr(IDX_CONTROL, 16'h0002);
    poll();
    check_setup(3'h0);
    // A reload cut short by reset must not leave the next boot confused.
    wr(IDX_CONTROL, 16'h0002);
    repeat (6) @(negedge core_clk);
    for (int k = 1; k < 8; k++)
    begin
      do_reset(3'(k), 1'b1);
      check_setup(3'(k));
    end
    do_reset(3'h0, 1'b0);
    rd(IDX_CONFIG, CONFIG_DEFAULT);
    rd(IDX_IA0, IA_DEFAULT);
    wr(IDX_CONTROL, 16'h0002);
    rd(IDX_CONTROL, 16'h0000, 16'h0006);
    repeat (4) @(negedge core_clk);
    stop_test();
  end

  initial
  begin
    #400000;
    check("watchdog", 16'h0000, 16'h0001);
    stop_test();
  end
endmodule
